// *** logic/olg_consts.svh ***
// Constants of the octal line interface global control register bank
// Assumes an eight-bit host port sampled on the system clock
`ifndef OLG_CONSTS_SVH
`define OLG_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OLG_A_DRV_STATUS 8'h05
`define OLG_A_DRV_MASK   8'h07
`define OLG_A_DRV_FLAGS  8'h09
`define OLG_A_SOFT_RST   8'h0a
`define OLG_A_MON        8'h0b
`define OLG_A_LOOP       8'h0c
`define OLG_A_CRIT       8'h0d
`define OLG_A_AUTO1      8'h0e
`define OLG_A_GLOBAL     8'h0f
`define OLG_A_TPTR       8'h10
`define OLG_A_TMPL       8'h11

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define OLG_RST_BYTE 8'h00
`define OLG_RST_SOFT 8'hff
`define OLG_RST_TMPL 3'h0

// ----------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------
`define OLG_G_AIS    6
`define OLG_G_SCP    5
`define OLG_G_AMI    4
`define OLG_G_DEPTH  3
`define OLG_G_BW     2
`define OLG_G_JA_HI  1
`define OLG_G_JA_LO  0
`define OLG_M_TX     3
`define OLG_JA_TX    2'h1
`define OLG_JA_RX    2'h3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define OLG_SRST_NS 1000
`define OLG_CLK_NS  40

`endif

// *** logic/olg_ctrl_regs.sv ***
// Global control register bank of the octal line interface
// Assumes host strobes on the system clock; line status pins are async
`timescale 1ns/1ps
`include "olg_consts.svh"
module olg_ctrl_regs (
    input  wire logic            i_sys_clk,
    input  wire logic            i_rstn,
    input  wire logic [7:0]      i_host_addr,
    input  wire logic [7:0]      i_host_wdata,
    input  wire logic            i_host_wr,
    input  wire logic            i_host_rd,
    input  wire logic [7:0]      i_drv_fault,
    input  wire logic [7:0]      i_los,
    input  wire logic            i_e1_mode,
    output logic      [7:0]      o_host_rdata,
    output logic                 o_soft_reset_active,
    output logic      [7:0]      o_loopback,
    output logic      [7:0]      o_criteria_ets,
    output logic      [7:0]      o_tx_all_ones,
    output logic      [7:0]      o_ais_insert,
    output logic                 o_short_protect_en,
    output logic                 o_ami_sel,
    output logic                 o_ja_depth64,
    output logic                 o_ja_wide_bw,
    output logic                 o_ja_tx,
    output logic                 o_ja_rx,
    output logic                 o_mon_rx_en,
    output logic                 o_mon_tx_en,
    output logic      [2:0]      o_mon_channel,
    output logic      [7:0][2:0] o_pulse_template_select
);
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int SrstCycles =
        (`OLG_SRST_NS + `OLG_CLK_NS - 1) / `OLG_CLK_NS;
    localparam logic [4:0] SrstLoad = 5'(SrstCycles - 1);

    olg_pkg::olg_state_t st;
    olg_pkg::olg_state_t next_st;
    logic [7:0]          set_vec;
    logic [7:0]          clr_vec;
    logic                tmpl_we;
    logic                host_wr_ok;
    logic [7:0][2:0]     tmpl_words;

    // ------------------------------------------------------------------
    // Flag causes
    // ------------------------------------------------------------------
    assign set_vec    = (st.df_sync ^ st.df_prev) & st.mask;
    assign clr_vec    = (i_host_rd && (i_host_addr == `OLG_A_DRV_STATUS))
                        ? 8'hff : 8'h00;
    assign host_wr_ok = i_host_wr && (st.mode == olg_pkg::olg_run);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st          = st;
        tmpl_we          = 1'b0;
        next_st.df_meta  = i_drv_fault;
        next_st.df_sync  = st.df_meta;
        next_st.df_prev  = st.df_sync;
        next_st.los_meta = i_los;
        next_st.los_sync = st.los_meta;
        next_st.e1_meta  = i_e1_mode;
        next_st.e1_sync  = st.e1_meta;
        if (st.mode == olg_pkg::olg_clear) begin
            next_st.flags = `OLG_RST_BYTE;
            next_st.mask  = `OLG_RST_BYTE;
            next_st.mon   = `OLG_RST_BYTE;
            next_st.digital_loopback_enables   = `OLG_RST_BYTE;
            next_st.loss_alarm_criteria   = `OLG_RST_BYTE;
            next_st.auto_all_ones_enables  = `OLG_RST_BYTE;
            next_st.global_settings   = `OLG_RST_BYTE;
            next_st.tptr  = `OLG_RST_BYTE;
            if (st.cnt == 5'h00) begin
                next_st.mode = olg_pkg::olg_run;
            end else begin
                next_st.cnt = st.cnt - 5'h01;
            end
        end else begin
            next_st.flags = (st.flags & ~clr_vec) | set_vec;
            if (host_wr_ok) begin
                if (i_host_addr == `OLG_A_DRV_MASK) begin
                    next_st.mask = i_host_wdata;
                end else if (i_host_addr == `OLG_A_SOFT_RST) begin
                    next_st.mode = olg_pkg::olg_clear;
                    next_st.cnt  = SrstLoad;
                end else if (i_host_addr == `OLG_A_MON) begin
                    next_st.mon = i_host_wdata;
                end else if (i_host_addr == `OLG_A_LOOP) begin
                    next_st.digital_loopback_enables = i_host_wdata;
                end else if (i_host_addr == `OLG_A_CRIT) begin
                    next_st.loss_alarm_criteria = i_host_wdata;
                end else if (i_host_addr == `OLG_A_AUTO1) begin
                    next_st.auto_all_ones_enables = i_host_wdata;
                end else if (i_host_addr == `OLG_A_GLOBAL) begin
                    next_st.global_settings = i_host_wdata;
                end else if (i_host_addr == `OLG_A_TPTR) begin
                    next_st.tptr = i_host_wdata;
                end else if (i_host_addr == `OLG_A_TMPL) begin
                    tmpl_we = 1'b1;
                end
            end
        end
        if (i_host_rd) begin
            if (i_host_addr == `OLG_A_DRV_STATUS) begin
                next_st.rdata = st.df_sync;
            end else if (i_host_addr == `OLG_A_DRV_MASK) begin
                next_st.rdata = st.mask;
            end else if (i_host_addr == `OLG_A_DRV_FLAGS) begin
                next_st.rdata = st.flags;
            end else if (i_host_addr == `OLG_A_SOFT_RST) begin
                next_st.rdata = `OLG_RST_SOFT;
            end else if (i_host_addr == `OLG_A_MON) begin
                next_st.rdata = st.mon;
            end else if (i_host_addr == `OLG_A_LOOP) begin
                next_st.rdata = st.digital_loopback_enables;
            end else if (i_host_addr == `OLG_A_CRIT) begin
                next_st.rdata = st.loss_alarm_criteria;
            end else if (i_host_addr == `OLG_A_AUTO1) begin
                next_st.rdata = st.auto_all_ones_enables;
            end else if (i_host_addr == `OLG_A_GLOBAL) begin
                next_st.rdata = st.global_settings;
            end else if (i_host_addr == `OLG_A_TPTR) begin
                next_st.rdata = st.tptr;
            end else if (i_host_addr == `OLG_A_TMPL) begin
                next_st.rdata = {5'h00, tmpl_words[st.tptr[2:0]]};
            end else begin
                next_st.rdata = 8'h00;
            end
        end
        next_st.srst_on = (next_st.mode == olg_pkg::olg_clear);
        next_st.tx1     = next_st.auto_all_ones_enables & next_st.los_sync;
        next_st.ais     = {8{next_st.global_settings[`OLG_G_AIS]}}
                          & next_st.los_sync;
        next_st.crit    = next_st.loss_alarm_criteria & {8{next_st.e1_sync}};
        next_st.mon_ch  = next_st.mon[2:0];
        next_st.mon_rx  = !next_st.mon[`OLG_M_TX]
                          && (next_st.mon[2:0] != 3'h0);
        next_st.mon_tx  = next_st.mon[`OLG_M_TX]
                          && (next_st.mon[2:0] != 3'h0);
        next_st.scp_en  = !next_st.global_settings[`OLG_G_SCP];
        next_st.ja_tx   = next_st.global_settings[`OLG_G_JA_HI:`OLG_G_JA_LO]
                          == `OLG_JA_TX;
        next_st.ja_rx   = next_st.global_settings[`OLG_G_JA_HI:`OLG_G_JA_LO]
                          == `OLG_JA_RX;
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st        <= '0;
            st.scp_en <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Template store
    // ------------------------------------------------------------------
    olg_tmpl_mem u_tmpl (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .i_clear   (st.srst_on),
        .i_we      (tmpl_we),
        .i_addr    (st.tptr[2:0]),
        .i_wdata   (i_host_wdata[2:0]),
        .o_words   (tmpl_words)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_host_rdata            = st.rdata;
    assign o_soft_reset_active     = st.srst_on;
    assign o_loopback              = st.digital_loopback_enables;
    assign o_criteria_ets          = st.crit;
    assign o_tx_all_ones           = st.tx1;
    assign o_ais_insert            = st.ais;
    assign o_short_protect_en      = st.scp_en;
    assign o_ami_sel               = st.global_settings[`OLG_G_AMI];
    assign o_ja_depth64            = st.global_settings[`OLG_G_DEPTH];
    assign o_ja_wide_bw            = st.global_settings[`OLG_G_BW];
    assign o_ja_tx                 = st.ja_tx;
    assign o_ja_rx                 = st.ja_rx;
    assign o_mon_rx_en             = st.mon_rx;
    assign o_mon_tx_en             = st.mon_tx;
    assign o_mon_channel           = st.mon_ch;
    assign o_pulse_template_select = tmpl_words;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);

    sequence srst_start_s;
        i_host_wr && (i_host_addr == `OLG_A_SOFT_RST)
        && (st.mode == olg_pkg::olg_run);
    endsequence

    sequence srst_hold_s;
        o_soft_reset_active [*8] ##1 o_soft_reset_active [*8]
        ##1 o_soft_reset_active [*8] ##1 o_soft_reset_active;
    endsequence

    flag_set_a: assert property (
        (st.mode == olg_pkg::olg_run) && (set_vec != 8'h00)
        |=> ((st.flags & $past(set_vec)) == $past(set_vec)))
        else $error("unmasked fault change did not set its flag");

    flag_clear_a: assert property (
        (st.mode == olg_pkg::olg_run) && (clr_vec == 8'hff)
        && (set_vec == 8'h00) |=> (st.flags == 8'h00))
        else $error("status read did not clear the fault flags");

    mask_block_a: assert property (
        (st.mode == olg_pkg::olg_run) && (st.mask == 8'h00)
        && !host_wr_ok && (clr_vec == 8'h00)
        |=> (st.flags == $past(st.flags)))
        else $error("masked fault change touched a flag");

    srst_len_a: assert property (
        srst_start_s |=> srst_hold_s ##1 !o_soft_reset_active)
        else $error("soft reset cycle length is wrong");

    srst_default_a: assert property (
        srst_start_s ##1 srst_hold_s |=> (o_loopback == 8'h00)
        && (st.global_settings == 8'h00) && (o_pulse_template_select == '0))
        else $error("soft reset left a register off its default");

    mon_write_a: assert property (
        host_wr_ok && (i_host_addr == `OLG_A_MON)
        && (i_host_wdata[2:0] == 3'h0)
        |=> !o_mon_rx_en && !o_mon_tx_en)
        else $error("monitor code zero did not stop monitoring");

    mon_route_a: assert property (
        host_wr_ok && (i_host_addr == `OLG_A_MON)
        && (i_host_wdata[3:0] > 4'h8)
        |=> o_mon_tx_en && !o_mon_rx_en
        && (o_mon_channel == $past(i_host_wdata[2:0])))
        else $error("monitor code did not route a transmitter");

    loop_write_a: assert property (
        host_wr_ok && (i_host_addr == `OLG_A_LOOP)
        |=> (o_loopback == $past(i_host_wdata)))
        else $error("loopback write not applied");

    all_ones_a: assert property (
        (o_tx_all_ones == (st.auto_all_ones_enables & st.los_sync)))
        else $error("all-ones output disagrees with loss and enable");

    ais_ins_a: assert property (
        !st.global_settings[`OLG_G_AIS] |-> (o_ais_insert == 8'h00))
        else $error("alarm inserted while insertion is off");

    ja_place_a: assert property (
        !(o_ja_tx && o_ja_rx))
        else $error("attenuator placed in both paths");

    crit_sel_a: assert property (
        o_criteria_ets == (st.e1_sync ? st.loss_alarm_criteria : 8'h00))
        else $error("criterion output disagrees with mode and register");

    scp_sel_a: assert property (
        o_short_protect_en == !st.global_settings[`OLG_G_SCP])
        else $error("short-circuit protection disagrees with bypass bit");

    code_sel_a: assert property (
        host_wr_ok && (i_host_addr == `OLG_A_GLOBAL)
        |=> (o_ami_sel == $past(i_host_wdata[`OLG_G_AMI])))
        else $error("line code select not applied");

    depth_sel_a: assert property (
        host_wr_ok && (i_host_addr == `OLG_A_GLOBAL)
        |=> (o_ja_depth64 == $past(i_host_wdata[`OLG_G_DEPTH])))
        else $error("attenuator depth select not applied");

    bw_sel_a: assert property (
        host_wr_ok && (i_host_addr == `OLG_A_GLOBAL)
        |=> (o_ja_wide_bw == $past(i_host_wdata[`OLG_G_BW])))
        else $error("attenuator bandwidth select not applied");

    ja_tx_a: assert property (
        host_wr_ok && (i_host_addr == `OLG_A_GLOBAL)
        && (i_host_wdata[1:0] == `OLG_JA_TX)
        |=> o_ja_tx && !o_ja_rx)
        else $error("attenuator not placed in transmit path");

    ja_rx_a: assert property (
        host_wr_ok && (i_host_addr == `OLG_A_GLOBAL)
        && (i_host_wdata[1:0] == `OLG_JA_RX)
        |=> o_ja_rx && !o_ja_tx)
        else $error("attenuator not placed in receive path");

    ja_off_a: assert property (
        host_wr_ok && (i_host_addr == `OLG_A_GLOBAL)
        && !i_host_wdata[`OLG_G_JA_LO]
        |=> !o_ja_tx && !o_ja_rx)
        else $error("attenuator placed although unused");

    ptr_write_a: assert property (
        host_wr_ok && (i_host_addr == `OLG_A_TPTR)
        |=> (st.tptr == $past(i_host_wdata)))
        else $error("template pointer write not applied");

    tmpl_write_a: assert property (
        host_wr_ok && (i_host_addr == `OLG_A_TMPL)
        |=> (o_pulse_template_select[$past(st.tptr[2:0])]
             == $past(i_host_wdata[2:0])))
        else $error("template write missed the pointed channel");

    srst_read_a: assert property (
        i_host_rd && (i_host_addr == `OLG_A_SOFT_RST)
        |=> (o_host_rdata == `OLG_RST_SOFT))
        else $error("soft reset register content changed");

    srst_clear_a: assert property (
        o_soft_reset_active |=> (o_loopback == 8'h00)
        && (o_tx_all_ones == 8'h00) && (st.tptr == 8'h00))
        else $error("register left set during soft reset");

    mon_rx_a: assert property (
        host_wr_ok && (i_host_addr == `OLG_A_MON)
        && !i_host_wdata[`OLG_M_TX] && (i_host_wdata[2:0] != 3'h0)
        |=> o_mon_rx_en && !o_mon_tx_en
        && (o_mon_channel == $past(i_host_wdata[2:0])))
        else $error("monitor code did not route a receiver");

    sequence status_read_s;
        i_host_rd && (i_host_addr == `OLG_A_DRV_STATUS);
    endsequence

    sequence status_data_s;
        o_host_rdata == $past(st.df_sync);
    endsequence

    status_read_a: assert property (
        status_read_s |=> status_data_s)
        else $error("status read returned wrong data");

endmodule

// *** logic/olg_pkg.sv ***
// Types of the octal line interface global control register bank
// Assumes one system clock domain
package olg_pkg;

    typedef enum logic {
        olg_run,
        olg_clear
    } olg_mode_t;

    typedef struct packed {
        olg_mode_t  mode;
        logic [4:0] cnt;
        logic       srst_on;
        logic [7:0] df_meta;
        logic [7:0] df_sync;
        logic [7:0] df_prev;
        logic [7:0] los_meta;
        logic [7:0] los_sync;
        logic       e1_meta;
        logic       e1_sync;
        logic [7:0] flags;
        logic [7:0] mask;
        logic [7:0] mon;
        logic [7:0] digital_loopback_enables;
        logic [7:0] loss_alarm_criteria;
        logic [7:0] auto_all_ones_enables;
        logic [7:0] global_settings;
        logic [7:0] tptr;
        logic [7:0] rdata;
        logic [7:0] crit;
        logic [7:0] tx1;
        logic [7:0] ais;
        logic       mon_rx;
        logic       mon_tx;
        logic [2:0] mon_ch;
        logic       scp_en;
        logic       ja_tx;
        logic       ja_rx;
    } olg_state_t;

    typedef struct packed {
        logic [7:0][2:0] word;
    } olg_mem_t;

endpackage

// *** logic/olg_tmpl_mem.sv ***
// Per-channel pulse template store, eight words of three bits
// Assumes write strobe and clear come from logic on the same clock
`timescale 1ns/1ps
`include "olg_consts.svh"
module olg_tmpl_mem (
    input  wire logic            i_sys_clk,
    input  wire logic            i_rstn,
    input  wire logic            i_clear,
    input  wire logic            i_we,
    input  wire logic [2:0]      i_addr,
    input  wire logic [2:0]      i_wdata,
    output logic      [7:0][2:0] o_words
);
    olg_pkg::olg_mem_t st;
    olg_pkg::olg_mem_t next_st;

    always_comb begin
        next_st = st;
        for (int i = 0; i < 8; i++) begin
            if (i_clear) begin
                next_st.word[i] = `OLG_RST_TMPL;
            end else if (i_we && (i_addr == 3'(i))) begin
                next_st.word[i] = i_wdata;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_words = st.word;
endmodule

// *** tb/olg_host_model.sv ***
// Host processor model driving the register port of the bank
// Assumes the bank samples its strobes on the rising clock edge
`timescale 1ns/1ps
module olg_host_model (
    input  wire logic       i_sys_clk,
    input  wire logic [7:0] i_rdata,
    output logic      [7:0] o_addr,
    output logic      [7:0] o_wdata,
    output logic            o_wr,
    output logic            o_rd
);
    initial begin
        o_addr  = 8'h00;
        o_wdata = 8'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end

    // ------------------------------------------------------------------
    // Bus cycles, launched and released on the falling edge
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        case (a)
            8'h0b: v = d & 8'h0f;
            8'h0f: v = d & 8'h7f;
            8'h10: v = d & 8'h07;
            default: v = d;
        endcase
        @(negedge i_sys_clk);
        o_addr  = a;
        o_wdata = v;
        o_wr    = 1'b1;
        @(negedge i_sys_clk);
        o_wr    = 1'b0;
        o_addr  = ~a;
        o_wdata = ~v;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_sys_clk);
        o_addr = a;
        o_rd   = 1'b1;
        @(negedge i_sys_clk);
        o_rd   = 1'b0;
        o_addr = ~a;
        @(negedge i_sys_clk);
        d = i_rdata;
    endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench of the global control register bank
// Assumes the host model performs all register cycles
`timescale 1ns/1ps
`include "olg_consts.svh"
module tb;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] q;
    } olg_row_t;

    logic            i_sys_clk;
    logic            i_rstn;
    logic [7:0]      i_host_addr, i_host_wdata, o_host_rdata;
    logic            i_host_wr, i_host_rd, i_e1_mode;
    logic [7:0]      i_drv_fault, i_los, rb;
    logic            o_soft_reset_active, o_short_protect_en, o_ami_sel;
    logic [7:0]      o_loopback, o_criteria_ets, o_tx_all_ones;
    logic [7:0]      o_ais_insert;
    logic            o_ja_depth64, o_ja_wide_bw, o_ja_tx, o_ja_rx;
    logic            o_mon_rx_en, o_mon_tx_en;
    logic [2:0]      o_mon_channel;
    logic [7:0][2:0] o_pulse_template_select;
    logic [42:0]     outs;
    int              fail_count;
    int              num_checks;
    int              cnt;
    olg_row_t        rows [6] = '{'{8'h0c, 8'h55, 8'h55},
        '{8'h0c, 8'haa, 8'haa}, '{8'h0d, 8'hf0, 8'hf0},
        '{8'h0d, 8'h0f, 8'h0f}, '{8'h0e, 8'h81, 8'h00},
        '{8'h0e, 8'hff, 8'h3c}};

    assign outs = {o_loopback, o_criteria_ets, o_tx_all_ones, o_ais_insert,
        o_short_protect_en, o_ami_sel, o_ja_depth64, o_ja_wide_bw,
        o_ja_tx, o_ja_rx, o_mon_rx_en, o_mon_tx_en, o_mon_channel};

    olg_ctrl_regs olg_ctrl_regs_i (
        .i_sys_clk, .i_rstn, .i_host_addr, .i_host_wdata, .i_host_wr,
        .i_host_rd, .i_drv_fault, .i_los, .i_e1_mode, .o_host_rdata,
        .o_soft_reset_active, .o_loopback, .o_criteria_ets, .o_tx_all_ones,
        .o_ais_insert, .o_short_protect_en, .o_ami_sel, .o_ja_depth64,
        .o_ja_wide_bw, .o_ja_tx, .o_ja_rx, .o_mon_rx_en, .o_mon_tx_en,
        .o_mon_channel, .o_pulse_template_select
    );

    olg_host_model olg_host_model_i (
        .i_sys_clk (i_sys_clk),
        .i_rdata   (o_host_rdata),
        .o_addr    (i_host_addr),
        .o_wdata   (i_host_wdata),
        .o_wr      (i_host_wr),
        .o_rd      (i_host_rd)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input string n, input logic [63:0] s,
                       input logic [63:0] e);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic print_verdict();
        if (fail_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    function automatic logic [7:0] out_of(input logic [7:0] a);
        case (a)
            8'h0c: return o_loopback;
            8'h0d: return o_criteria_ets;
            default: return o_tx_all_ones;
        endcase
    endfunction

    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end

    initial begin
        repeat (20000) @(posedge i_sys_clk);
        fail_count++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        fail_count  = 0;
        num_checks  = 0;
        i_rstn      = 1'b0;
        i_drv_fault = 8'h00;
        i_los       = 8'h3c;
        i_e1_mode   = 1'b1;
        repeat (20) @(negedge i_sys_clk);
        i_rstn = 1'b1;
        @(negedge i_sys_clk);
        chk("reset outs", outs, 44'h1 << 10);
        chk("reset tmpl", o_pulse_template_select, 24'h0);
        for (int a = 9; a <= 16; a++) begin
            olg_host_model_i.rd(8'(a), rb);
            chk("reset reg", rb, (a == 10) ? 8'hff : 8'h00);
        end
        foreach (rows[i]) begin
            olg_host_model_i.wr(rows[i].a, rows[i].d);
            repeat (4) @(negedge i_sys_clk);
            chk("row out", out_of(rows[i].a), rows[i].q);
            olg_host_model_i.rd(rows[i].a, rb);
            chk("row rd", rb, rows[i].d);
        end
        i_los = 8'h00;
        repeat (5) @(negedge i_sys_clk);
        chk("all ones off", o_tx_all_ones, 8'h00);
        i_e1_mode = 1'b0;
        repeat (5) @(negedge i_sys_clk);
        chk("t1 crit", o_criteria_ets, 8'h00);
        i_e1_mode = 1'b1;
        i_los = 8'h3c;
        for (int c = 0; c < 16; c++) begin
            olg_host_model_i.wr(8'h0b, 8'(c));
            @(negedge i_sys_clk);
            chk("mon", {o_mon_rx_en, o_mon_tx_en, o_mon_channel},
                {!c[3] && c[2:0] != 0, c[3] && c[2:0] != 0,
                c[2:0]});
        end
        for (int d = 0; d < 128; d++) begin
            olg_host_model_i.wr(8'h0f, 8'(d));
            repeat (2) @(negedge i_sys_clk);
            chk("global", outs[18:5], {d[6] ? i_los : 8'h00, !d[5], d[4],
                d[3], d[2], d[1:0] == 2'b01,
                d[1:0] == 2'b11});
            olg_host_model_i.rd(8'h0f, rb);
            chk("global rd", rb, 8'(d));
        end
        for (int n = 0; n < 8; n++) begin
            olg_host_model_i.wr(8'h10, 8'(n));
            olg_host_model_i.wr(8'h11, 8'(7 - n));
            olg_host_model_i.rd(8'h11, rb);
            chk("tmpl rd", rb, 8'(7 - n));
        end
        chk("tmpl", o_pulse_template_select, 24'h053977);
        olg_host_model_i.rd(8'h10, rb);
        chk("pointer", rb, 8'h07);
        olg_host_model_i.wr(8'h07, 8'h0f);
        i_drv_fault = 8'hff;
        repeat (6) @(negedge i_sys_clk);
        olg_host_model_i.rd(8'h09, rb);
        chk("flags", rb, 8'h0f);
        olg_host_model_i.rd(8'h05, rb);
        chk("status", rb, 8'hff);
        olg_host_model_i.rd(8'h09, rb);
        chk("flags clr", rb, 8'h00);
        olg_host_model_i.wr(8'h0a, 8'h00);
        olg_host_model_i.wr(8'h0c, 8'hff);
        cnt = 2;
        while (o_soft_reset_active === 1'b1 && cnt < 100) begin
            cnt++;
            @(negedge i_sys_clk);
        end
        chk("srst len", cnt,
            (`OLG_SRST_NS + `OLG_CLK_NS - 1) / `OLG_CLK_NS);
        chk("srst outs", outs, 44'h1 << 10);
        chk("srst tmpl", o_pulse_template_select, 24'h0);
        olg_host_model_i.rd(8'h0c, rb);
        chk("srst loop", rb, 8'h00);
        olg_host_model_i.rd(8'h0a, rb);
        chk("srst reg", rb, 8'hff);
        olg_host_model_i.wr(8'h0f, 8'h20);
        i_rstn = 1'b0;
        repeat (2) @(negedge i_sys_clk);
        i_rstn = 1'b1;
        @(negedge i_sys_clk);
        chk("rst2 outs", outs, 44'h1 << 10);
        olg_host_model_i.rd(8'h0f, rb);
        chk("rst2 global", rb, 8'h00);
        print_verdict();
    end
endmodule
